// File: rtl/timer_flag_output_ctrl.sv
// Flag, output and run control of a pair of 8-bit timers joinable into one 16-bit timer
`timescale 1ns/100ps
`default_nettype none
`include "timer_flag_cfg.svh"

module timer_flag_output_ctrl (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output timer_flag_pkg::resp_t       s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output timer_flag_pkg::resp_t       s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [1:0]             measure_in,
  output logic [1:0]                  timer_pin_out,
  output logic [1:0]                  timer_pin_oe,
  output logic [1:0]                  irq_req
);
  import timer_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [1:0]   run_enable, suspend, irq_enable, edge_measure_flag;
  logic [1:0]   buffer_full_flag, match_flag, init_value, output_enable;
  logic [1:0]   match_flag_irq_enable, out_level, meas_q;
  func_t        function_select [2];
  byte_t        data_reg [2];
  count_t       count [2];
  logic         wide_mode_select;
  logic [7:0]   aw_addr;
  logic [7:0]   w_byte;
  logic         aw_full, w_full, w_strb0;

  // Function decode shared by both channels
  function automatic logic is_pwc(input func_t f);
    return f == `TFC_FS_PWC_HIGH || f == `TFC_FS_PWC_HCYC || f == `TFC_FS_PWC_LOW;
  endfunction
  function automatic logic is_interval(input func_t f);
    return f == `TFC_FS_ONESHOT || f == `TFC_FS_CONT;
  endfunction
  function automatic logic is_pwm(input func_t f);
    return f == `TFC_FS_FIXPWM || f == `TFC_FS_VARPWM;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus write and read decode
  logic       wr_fire, rd_fire, wr_ok, rd_ok;
  logic [1:0] wr_ctl1, wr_ctl0, wr_data, rd_data;
  logic       wr_pair;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ctl1 = {aw_addr == `TFC_OFS_B_CTL1, aw_addr == `TFC_OFS_A_CTL1} & {2{wr_fire && w_strb0}};
  assign wr_ctl0 = {aw_addr == `TFC_OFS_B_CTL0, aw_addr == `TFC_OFS_A_CTL0} & {2{wr_fire && w_strb0}};
  assign wr_data = {aw_addr == `TFC_OFS_B_DATA, aw_addr == `TFC_OFS_A_DATA} & {2{wr_fire && w_strb0}};
  assign wr_pair = wr_fire && w_strb0 && aw_addr == `TFC_OFS_PAIR;
  assign rd_data = {s_axi_araddr == `TFC_OFS_B_DATA, s_axi_araddr == `TFC_OFS_A_DATA}
                   & {2{rd_fire}};

  // Address map check used by both channels
  function automatic logic mapped(input logic [7:0] a);
    return a <= `TFC_OFS_B_DATA && a[1:0] == 2'b00 || a == `TFC_OFS_A_RMW || a == `TFC_OFS_B_RMW;
  endfunction
  assign wr_ok = mapped(aw_addr);
  assign rd_ok = mapped(s_axi_araddr);

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel event terms
  logic       coupled;
  logic [1:0] active, rise, fall, ovf, hit, start, stop, xfer, xfer_cyc, cap_evt, pwc_end;
  logic [1:0] restart, rd_clear, mf_set;
  count_t     top [2];
  count_t     cmp [2];
  assign coupled = wide_mode_select || function_select[0] == `TFC_FS_VARPWM;
  assign top[0]  = wide_mode_select ? 16'hFFFF : 16'h00FF;
  assign top[1]  = 16'h00FF;
  assign cmp[0]  = wide_mode_select ? {data_reg[1], data_reg[0]} : {8'h00, data_reg[0]};
  assign cmp[1]  = {8'h00, data_reg[1]};
  // Lower read clears in 8-bit mode, upper read clears lower flag when wide
  // read clears flag
  assign rd_clear[0] = wide_mode_select ? rd_data[1] : rd_data[0];
  assign rd_clear[1] = !wide_mode_select && rd_data[1];

  for (genvar i = 0; i < 2; i++) begin : g_evt
    assign active[i]  = run_enable[i] && !suspend[i] && !(wide_mode_select && i == 1);
    assign rise[i]    = measure_in[i] && !meas_q[i];
    assign fall[i]    = !measure_in[i] && meas_q[i];
    assign ovf[i]     = active[i] && count[i] == top[i];
    assign hit[i]     = active[i] && count[i] == cmp[i];
    assign start[i]   = wr_ctl1[i] && w_byte[`TFC_BIT_RUN] && !run_enable[i];
    assign stop[i]    = wr_ctl1[i] && !w_byte[`TFC_BIT_RUN];
    assign pwc_end[i] = active[i] && (function_select[i] == `TFC_FS_PWC_LOW ? rise[i] : fall[i]);
    assign restart[i] = active[i] && (function_select[i] == `TFC_FS_PWC_LOW ? fall[i] : rise[i]);
    assign cap_evt[i] = active[i] && function_select[i] == `TFC_FS_CAPTURE && (rise[i] || fall[i]);
    // full flag blocks transfer except high pulse of 1001
    assign xfer[i]     = is_pwc(function_select[i]) && pwc_end[i]
                         && (!buffer_full_flag[i] || function_select[i] == `TFC_FS_PWC_HCYC);
    assign xfer_cyc[i] = function_select[i] == `TFC_FS_PWC_HCYC && restart[i]
                         && !buffer_full_flag[i];
    // match in interval, overflow in measuring modes
    assign mf_set[i]  = is_interval(function_select[i]) ? hit[i]
                        : ((is_pwc(function_select[i]) || function_select[i] == `TFC_FS_CAPTURE)
                           && ovf[i]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and run control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count      <= '{default: 16'h0000};
      run_enable <= 2'b00;
      suspend    <= 2'b00;
      meas_q     <= 2'b00;
    end else begin
      meas_q <= measure_in;
      for (int i = 0; i < 2; i++) begin
        if (start[i] || stop[i] || (coupled && (start[1-i] || stop[1-i])))
          count[i] <= 16'h0000;
        else if (active[i] && (is_pwc(function_select[i]) && restart[i]
                 || is_interval(function_select[i]) && hit[i]))
          count[i] <= 16'h0000;
        else if (active[i])
          count[i] <= (count[i] + 16'h0001) & top[i];
        if (wr_ctl1[i]) begin
          run_enable[i] <= w_byte[`TFC_BIT_RUN];
          suspend[i]    <= w_byte[`TFC_BIT_SUSP];
        end else if (coupled && wr_ctl1[1-i]) begin
          run_enable[i] <= w_byte[`TFC_BIT_RUN];
          suspend[i]    <= w_byte[`TFC_BIT_SUSP];
        end else if (function_select[i] == `TFC_FS_ONESHOT && hit[i]) begin
          run_enable[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register: software compare value or captured count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= '{default: `TFC_RST_BYTE};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (xfer[i] || xfer_cyc[i] || cap_evt[i]) begin
          data_reg[i] <= count[i][7:0];
          if (i == 0 && wide_mode_select)
            data_reg[1] <= count[0][15:8];
        end else if (wr_data[i]) begin
          data_reg[i] <= w_byte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_full_flag  <= 2'b00;
      match_flag        <= 2'b00;
      edge_measure_flag <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // flag only lives in pulse-width modes
        if (!is_pwc(function_select[i]) || (wide_mode_select && i == 1))
          buffer_full_flag[i] <= 1'b0;
        else if (xfer[i] || xfer_cyc[i])
          buffer_full_flag[i] <= 1'b1;
        else if (rd_clear[i])
          buffer_full_flag[i] <= 1'b0;
        if (function_select[i] == `TFC_FS_VARPWM || (wide_mode_select && i == 1))
          match_flag[i] <= 1'b0;
        else if (mf_set[i])
          match_flag[i] <= 1'b1;
        else if (wr_ctl1[i] && !w_byte[`TFC_BIT_MF])
          match_flag[i] <= 1'b0;
        if (!(is_pwc(function_select[i]) || function_select[i] == `TFC_FS_CAPTURE)
            || (wide_mode_select && i == 1))
          edge_measure_flag[i] <= 1'b0;
        else if (pwc_end[i] && is_pwc(function_select[i]) || cap_evt[i])
          edge_measure_flag[i] <= 1'b1;
        else if (wr_ctl1[i] && !w_byte[`TFC_BIT_EDGE])
          edge_measure_flag[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_value            <= 2'b00;
      output_enable         <= 2'b00;
      irq_enable            <= 2'b00;
      match_flag_irq_enable <= 2'b00;
      function_select       <= '{default: `TFC_RST_FS};
      wide_mode_select      <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctl1[i]) begin
          output_enable[i] <= w_byte[`TFC_BIT_OE];
          irq_enable[i]    <= w_byte[`TFC_BIT_IRQEN];
          if (!(run_enable[0] || run_enable[1]) || (wide_mode_select && i == 1))
            init_value[i] <= w_byte[`TFC_BIT_INIT];
        end
        if (wr_ctl0[i]) begin
          function_select[i]       <= w_byte[3:0];
          match_flag_irq_enable[i] <= w_byte[`TFC_BIT_MFIE];
        end
      end
      if (wr_pair)
        wide_mode_select <= w_byte[`TFC_BIT_WIDE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer output level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_level <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wide_mode_select && i == 1)
          out_level[1] <= out_level[0];
        else if (start[i] || (coupled && i == 1 && start[0]))
          out_level[i] <= (is_pwm(function_select[i]) || function_select[i] == `TFC_FS_CAPTURE)
                          ? 1'b0 : init_value[wide_mode_select ? 0 : i];
        else if (is_interval(function_select[i]) && hit[i])
          out_level[i] <= !out_level[i];
        else if (is_pwm(function_select[i]) && hit[i])
          out_level[i] <= 1'b0;
        else if (is_pwm(function_select[i]) && ovf[i])
          out_level[i] <= 1'b1;
      end
    end
  end

  assign timer_pin_out = out_level & output_enable;
  assign timer_pin_oe  = output_enable;
  assign irq_req = irq_enable & (edge_measure_flag | (match_flag & match_flag_irq_enable));

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= 8'h00;
      w_byte       <= 8'h00;
      w_strb0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_strb0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TFC_RESP_OKAY : `TFC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  function automatic byte_t ctl1_view(input int i, input logic rmw);
    return {run_enable[i], suspend[i], irq_enable[i], edge_measure_flag[i] | rmw,
            buffer_full_flag[i], match_flag[i] | rmw, init_value[i], output_enable[i]};
  endfunction
  byte_t rd_byte;
  always_comb begin
    unique case (s_axi_araddr)
      `TFC_OFS_A_CTL1: rd_byte = ctl1_view(0, 1'b0);
      `TFC_OFS_B_CTL1: rd_byte = ctl1_view(1, 1'b0);
      `TFC_OFS_A_CTL0: rd_byte = {3'b000, match_flag_irq_enable[0], function_select[0]};
      `TFC_OFS_B_CTL0: rd_byte = {3'b000, match_flag_irq_enable[1], function_select[1]};
      `TFC_OFS_PAIR:   rd_byte = {5'b00000, out_level[1], out_level[0], wide_mode_select};
      `TFC_OFS_A_DATA: rd_byte = data_reg[0];
      `TFC_OFS_B_DATA: rd_byte = data_reg[1];
      // read-modify-write view returns edge and match flags as one, full flag as stored
      `TFC_OFS_A_RMW:  rd_byte = ctl1_view(0, 1'b1);
      `TFC_OFS_B_RMW:  rd_byte = ctl1_view(1, 1'b1);
      default:         rd_byte = 8'h00;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TFC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_ok ? `TFC_RESP_OKAY : `TFC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_start0;
    start[0] && !wide_mode_select && !is_pwm(function_select[0])
      && function_select[0] != `TFC_FS_CAPTURE;
  endsequence
  property p_bf_set;
    @(posedge aclk) disable iff (!aresetn)
      xfer[0] && !wide_mode_select |=> buffer_full_flag[0] && data_reg[0] == $past(count[0][7:0]);
  endproperty
  a_bf_set: assert property (p_bf_set) else $error("full flag or data not set on capture");
  property p_bf_rd;
    @(posedge aclk) disable iff (!aresetn)
      rd_data[0] && !wide_mode_select && !xfer[0] && !xfer_cyc[0] |=> !buffer_full_flag[0];
  endproperty
  a_bf_rd: assert property (p_bf_rd) else $error("read did not clear full flag");
  property p_bf_hold;
    @(posedge aclk) disable iff (!aresetn)
      buffer_full_flag[0] && function_select[0] == `TFC_FS_PWC_HIGH && !wr_data[0]
      && !wide_mode_select |=> $stable(data_reg[0]);
  endproperty
  a_bf_hold: assert property (p_bf_hold) else $error("data changed while full");
  property p_hcyc;
    @(posedge aclk) disable iff (!aresetn)
      buffer_full_flag[0] && function_select[0] == `TFC_FS_PWC_HCYC && pwc_end[0]
      && !wide_mode_select |=> data_reg[0] == $past(count[0][7:0]);
  endproperty
  a_hcyc: assert property (p_hcyc) else $error("high pulse not transferred");
  property p_bf_wide;
    @(posedge aclk) disable iff (!aresetn)
      wide_mode_select && rd_data[1] && !xfer[0] && !xfer_cyc[0] |=> !buffer_full_flag[0];
  endproperty
  a_bf_wide: assert property (p_bf_wide) else $error("upper read left lower flag");
  property p_bf_zero;
    @(posedge aclk) disable iff (!aresetn)
      !is_pwc(function_select[0]) |=> !buffer_full_flag[0];
  endproperty
  a_bf_zero: assert property (p_bf_zero) else $error("full flag outside pulse mode");
  property p_mf_hit;
    @(posedge aclk) disable iff (!aresetn)
      is_interval(function_select[0]) && hit[0] && !wr_ctl0[0] |=> match_flag[0];
  endproperty
  a_mf_hit: assert property (p_mf_hit) else $error("match did not set flag");
  property p_rmw;
    @(posedge aclk) disable iff (!aresetn)
      rd_fire && s_axi_araddr == `TFC_OFS_A_RMW |=> s_axi_rvalid && s_axi_rdata[`TFC_BIT_MF];
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw view lost match bit");
  property p_mf_one;
    @(posedge aclk) disable iff (!aresetn)
      match_flag[0] && wr_ctl1[0] && w_byte[`TFC_BIT_MF] |=> match_flag[0] || wr_ctl0[0] != 1'b0
        || $past(function_select[0]) == `TFC_FS_VARPWM;
  endproperty
  a_mf_one: assert property (p_mf_one) else $error("writing one cleared match flag");
  property p_mf_var;
    @(posedge aclk) disable iff (!aresetn)
      function_select[0] == `TFC_FS_VARPWM |=> !match_flag[0];
  endproperty
  a_mf_var: assert property (p_mf_var) else $error("match flag set in variable PWM");
  property p_mf_wide;
    @(posedge aclk) disable iff (!aresetn) wide_mode_select |=> !match_flag[1];
  endproperty
  a_mf_wide: assert property (p_mf_wide) else $error("upper match flag set when wide");
  property p_init;
    @(posedge aclk) disable iff (!aresetn) s_start0 |=> out_level[0] == $past(init_value[0]);
  endproperty
  a_init: assert property (p_init) else $error("initial value not loaded at start");
  property p_pin;
    @(posedge aclk) disable iff (!aresetn)
      timer_pin_oe == output_enable && (timer_pin_out & ~output_enable) == 2'b00;
  endproperty
  a_pin: assert property (p_pin) else $error("pin drive disagrees with enable");
endmodule
`default_nettype wire

// File: rtl/timer_flag_cfg.svh
// Offsets, bit positions, reset values and function codes of the timer pair
`ifndef TIMER_FLAG_CFG_SVH
`define TIMER_FLAG_CFG_SVH

// Register byte offsets
`define TFC_OFS_A_CTL1   8'h00
`define TFC_OFS_B_CTL1   8'h04
`define TFC_OFS_A_CTL0   8'h08
`define TFC_OFS_B_CTL0   8'h0C
`define TFC_OFS_PAIR     8'h10
`define TFC_OFS_A_DATA   8'h14
`define TFC_OFS_B_DATA   8'h18
`define TFC_OFS_A_RMW    8'h20
`define TFC_OFS_B_RMW    8'h24

// Status/control one bit positions
`define TFC_BIT_RUN      7
`define TFC_BIT_SUSP     6
`define TFC_BIT_IRQEN    5
`define TFC_BIT_EDGE     4
`define TFC_BIT_BF       3
`define TFC_BIT_MF       2
`define TFC_BIT_INIT     1
`define TFC_BIT_OE       0

// Control zero and pair control bit positions
`define TFC_BIT_MFIE     4
`define TFC_BIT_WIDE     0
`define TFC_BIT_LOWOUT   1
`define TFC_BIT_UPOUT    2

// Function select codes
`define TFC_FS_ONESHOT   4'h0
`define TFC_FS_CONT      4'h1
`define TFC_FS_FIXPWM    4'h2
`define TFC_FS_VARPWM    4'h4
`define TFC_FS_PWC_HIGH  4'h8
`define TFC_FS_PWC_HCYC  4'h9
`define TFC_FS_PWC_LOW   4'hA
`define TFC_FS_CAPTURE   4'hC

// Reset values
`define TFC_RST_BYTE     8'h00
`define TFC_RST_FS       4'h0

// Bus responses
`define TFC_RESP_OKAY    2'b00
`define TFC_RESP_SLVERR  2'b10

`endif

// File: rtl/timer_flag_pkg.sv
// Types shared by the timer pair flag and output control
package timer_flag_pkg;
  typedef logic [3:0]  func_t;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;
  typedef logic [1:0]  resp_t;
endpackage

// File: dv/pulse_source.sv
// Measured-input source that stands in for the external signal
`timescale 1ns/100ps
`default_nettype none

module pulse_source (
  input  wire logic       aclk,
  output logic [1:0]      measure_in
);
  initial measure_in = 2'b00;

  // High pulse of a given width on one input, low outside pulses
  task automatic pulse(input int idx, input int width);
    @(posedge aclk);
    measure_in[idx] <= 1'b1;
    repeat (width) @(posedge aclk);
    measure_in[idx] <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the timer flag and output control
`timescale 1ns/100ps
`default_nettype none
`include "timer_flag_cfg.svh"

module testbench;
  import timer_flag_pkg::*;
  typedef struct packed {byte_t a; byte_t d; byte_t e; resp_t r;} row_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  resp_t bresp, rresp, r;
  logic [1:0] measure_in, pin_out, pin_oe, irq;
  byte_t v, d1;
  int mismatches, n_tests;
  row_s rows[5] = '{{8'h08, 8'h08, 8'h08, 2'b00}, {8'h00, 8'h0F, 8'h03, 2'b00},
    {8'h1C, 8'h55, 8'h00, 2'b10}, {8'h10, 8'h00, 8'h00, 2'b00}, {8'h04, 8'h0D, 8'h01, 2'b00}};

  timer_flag_output_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .measure_in(measure_in), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .irq_req(irq));
  pulse_source src (.aclk(aclk), .measure_in(measure_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus write, both channels offered together
  task automatic wr(input byte_t a, input byte_t d);
    int i;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp; bready <= 1'b0;
    if (i == 50) begin mismatches++; stop_test(); end
  endtask

  // Bus read of the low byte
  task automatic rd(input byte_t a);
    int i;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata[7:0]; r = rresp; rready <= 1'b0;
    if (i == 50) begin mismatches++; stop_test(); end
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF; aresetn = 1'b0;
    mismatches = 0; n_tests = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); chk("reset_ctl1", v, 8'h00);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d); chk("wr_resp", r, rows[k].r);
      rd(rows[k].a); chk("rd_data", v, rows[k].e); chk("rd_resp", r, rows[k].r);
    end
    chk("oe", pin_oe, 2'b11);
    wr(8'h00, 8'h83); @(posedge aclk);
    chk("pin_init", pin_out[0], 1'b1);
    wr(8'h00, 8'h81); rd(8'h00); chk("init_locked", v & 8'h02, 8'h02);
    src.pulse(0, 20); rd(8'h00); chk("full_set", v & 8'h18, 8'h18);
    rd(8'h14); d1 = v; rd(8'h00); chk("full_clr", v & 8'h08, 8'h00);
    src.pulse(0, 20); src.pulse(0, 40);
    rd(8'h14); chk("data_held", v, d1);
    rd(8'h20); chk("rmw_view", v & 8'h14, 8'h14);
    repeat (300) @(posedge aclk);
    rd(8'h00); chk("overflow", v & 8'h04, 8'h04);
    // Suspend first so that no overflow sets the match flag again during the checks
    wr(8'h08, 8'h18); wr(8'h00, 8'hE5); rd(8'h00);
    chk("mf_keep", v & 8'h04, 8'h04);
    chk("irq_on", irq[0], 1'b1);
    wr(8'h00, 8'hE1); rd(8'h00); chk("mf_clear", v & 8'h04, 8'h00);
    chk("irq_off", irq[0], 1'b0);
    // Timer b in high pulse plus cycle mode, high result read before the cycle ends
    wr(8'h0C, 8'h09); wr(8'h04, 8'h81);
    src.pulse(1, 10); rd(8'h18); chk("hcyc_high", v, 8'h09);
    src.pulse(1, 12); rd(8'h04); chk("hcyc_full", v & 8'h08, 8'h08);
    rd(8'h18); chk("hcyc_next", v, 8'h0B);
    // Reset in mid-run returns registers and pins to idle
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); chk("rst_ctl1", v, 8'h00);
    rd(8'h18); chk("rst_data", v, 8'h00);
    chk("rst_oe", pin_oe, 2'b00);
    stop_test();
  end
endmodule
`default_nettype wire
